// File: common/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_START = 8'h00;
    localparam logic [7:0] OFF_POWER = 8'h04;
    localparam logic [7:0] OFF_REPEAT = 8'h08;
    localparam logic [7:0] OFF_SCAN = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h14;
    localparam logic [7:0] OFF_CLOCK = 8'h18;
    localparam logic [7:0] OFF_DMA = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] OFF_PRIORITY_RESULT = 8'h30;
    localparam logic [7:0] OFF_RESULT_BASE = 8'h40;

    // ==========================================================
    // Field positions
    localparam int START_NORMAL_BIT = 0;
    localparam int START_PRIORITY_BIT = 1;
    localparam int REPEAT_BIT = 0;
    localparam int SCAN_BIT = 1;
    localparam int ITM_LSB = 2;
    localparam int FIX_CH_LSB = 8;
    localparam int HP_CH_LSB = 12;
    localparam int CLK_SEL_LSB = 0;
    localparam int SH_LSB = 8;
    localparam int ST_EOCF_BIT = 0;
    localparam int ST_HPEOCF_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_HP_PEND_BIT = 3;
    localparam int IRQ_NORMAL_BIT = 0;
    localparam int IRQ_PRIORITY_BIT = 1;
    localparam int IRQ_REFUSED_BIT = 2;
    localparam int IRQ_BITS = 3;

    // ==========================================================
    // Reset values and codes
    localparam logic [2:0] CLK_SEL_RESET = 3'h0;
    localparam logic [6:0] SH_RESET = 7'h0a;
    localparam logic [3:0] SCAN_RANGE_RESET = 4'hc;
    localparam logic [1:0] SOFT_RESET_ARM = 2'h2;
    localparam logic [1:0] SOFT_RESET_FIRE = 2'h1;
    localparam logic [6:0] SH_MIN = 7'h0a;
    localparam logic [6:0] SH_MAX = 7'h50;
    localparam int NUM_CHANNELS = 12;
    localparam int DMA_DELAY = 2;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

endpackage

// File: logic/adc_ctrl.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module adc_ctrl #(
    parameter int DATA_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] analog_channel,
    output logic sample_en,
    output logic conv_req,
    input wire logic conv_valid,
    input wire logic [DATA_WIDTH-1:0] conv_data,
    output logic reference_enable,
    output logic normal_done_irq,
    output logic priority_done_irq,
    output logic dma_req,
    output logic irq
);

    initial begin
        if (DATA_WIDTH < 1 || DATA_WIDTH > 32) begin
            $error("adc_ctrl data width must be 1 to 32");
        end
    end

    localparam logic [3:0] LAST_CH = 4'(adc_ctrl_pkg::NUM_CHANNELS - 1);
    localparam logic [3:0] HP_SLOT = 4'(adc_ctrl_pkg::NUM_CHANNELS);

    // ==========================================================
    // APB access phase: one wait state on every transfer
    logic ack_reg;
    logic access;
    logic done_xfer;
    logic wr_xfer;
    logic rd_xfer;
    logic mapped;
    logic [31:0] rd_mux;

    assign access = psel && penable;
    assign done_xfer = access && ack_reg;
    assign wr_xfer = done_xfer && pwrite;
    assign rd_xfer = done_xfer && !pwrite;
    assign pready = done_xfer;
    assign pslverr = done_xfer && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access && !ack_reg;
        end
    end

    // ==========================================================
    // Configuration registers
    logic ref_en_reg;
    logic repeat_reg;
    logic scan_reg;
    logic [2:0] itm_reg;
    logic [3:0] fix_ch_reg;
    logic [3:0] hp_ch_reg;
    logic [3:0] scan_range_reg;
    logic [2:0] clk_sel_reg;
    logic [6:0] sh_reg;
    logic dma_en_reg;
    logic [adc_ctrl_pkg::IRQ_BITS-1:0] irq_en_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_en_reg <= 1'b0;
            repeat_reg <= 1'b0;
            scan_reg <= 1'b0;
            itm_reg <= 3'h0;
            fix_ch_reg <= 4'h0;
            hp_ch_reg <= 4'h0;
            scan_range_reg <= adc_ctrl_pkg::SCAN_RANGE_RESET;
            clk_sel_reg <= adc_ctrl_pkg::CLK_SEL_RESET;
            sh_reg <= adc_ctrl_pkg::SH_RESET;
            dma_en_reg <= 1'b0;
            irq_en_reg <= '0;
        end else if (wr_xfer) begin
            unique case (paddr)
                adc_ctrl_pkg::OFF_POWER: ref_en_reg <= pwdata[0];
                adc_ctrl_pkg::OFF_REPEAT: begin
                    repeat_reg <= pwdata[adc_ctrl_pkg::REPEAT_BIT];
                    scan_reg <= pwdata[adc_ctrl_pkg::SCAN_BIT];
                    itm_reg <= pwdata[adc_ctrl_pkg::ITM_LSB +: 3];
                    fix_ch_reg <= pwdata[adc_ctrl_pkg::FIX_CH_LSB +: 4];
                    hp_ch_reg <= pwdata[adc_ctrl_pkg::HP_CH_LSB +: 4];
                end
                adc_ctrl_pkg::OFF_SCAN: scan_range_reg <= pwdata[3:0];
                adc_ctrl_pkg::OFF_CLOCK: begin
                    clk_sel_reg <= pwdata[adc_ctrl_pkg::CLK_SEL_LSB +: 3];
                    sh_reg <= pwdata[adc_ctrl_pkg::SH_LSB +: 7];
                end
                adc_ctrl_pkg::OFF_DMA: dma_en_reg <= pwdata[0];
                adc_ctrl_pkg::OFF_IRQ_ENABLE: irq_en_reg <= pwdata[adc_ctrl_pkg::IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    assign reference_enable = ref_en_reg;

    // ==========================================================
    // Soft reset: an ordered pair of writes, any other soft reset write disarms
    logic armed_reg;
    logic soft_rst;

    assign soft_rst = wr_xfer && paddr == adc_ctrl_pkg::OFF_SOFT_RESET
        && pwdata[1:0] == adc_ctrl_pkg::SOFT_RESET_FIRE && armed_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b0;
        end else if (wr_xfer && paddr == adc_ctrl_pkg::OFF_SOFT_RESET) begin
            armed_reg <= pwdata[1:0] == adc_ctrl_pkg::SOFT_RESET_ARM;
        end
    end

    // ==========================================================
    // Converter clock tick: divide by 2*code, code 0 runs at pclk
    logic [3:0] div_cnt_reg;
    logic [3:0] div_last;
    logic tick;

    assign div_last = (clk_sel_reg == 3'h0) ? 4'h0 : 4'({clk_sel_reg, 1'b0} - 4'h1);
    assign tick = div_cnt_reg >= div_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 4'h0;
        end else begin
            div_cnt_reg <= tick ? 4'h0 : div_cnt_reg + 4'h1;
        end
    end

    // Out-of-range sample-hold settings saturate at the legal limits
    logic [6:0] sh_eff;
    assign sh_eff = (sh_reg < adc_ctrl_pkg::SH_MIN) ? adc_ctrl_pkg::SH_MIN :
        (sh_reg > adc_ctrl_pkg::SH_MAX) ? adc_ctrl_pkg::SH_MAX : sh_reg;

    // ==========================================================
    // Conversion sequencer
    adc_ctrl_pkg::conv_state_t state_reg;
    logic busy_reg;
    logic hp_pend_reg;
    logic hp_act_reg;
    logic [3:0] ch_reg;
    logic [3:0] slot_reg;
    logic [2:0] rep_cnt_reg;
    logic [6:0] sh_cnt_reg;
    logic range_ok;
    logic [3:0] scan_first;
    logic start_wr;
    logic hp_start_wr;
    logic start_ok;
    logic refused_ev;
    logic end_conv;
    logic norm_done_ev;
    logic hp_done_ev;
    logic seq_last;
    logic norm_go_on;

    assign range_ok = scan_range_reg != 4'h0 && scan_range_reg <= LAST_CH + 4'h1;
    assign scan_first = 4'(LAST_CH + 4'h1 - scan_range_reg);
    assign start_wr = wr_xfer && paddr == adc_ctrl_pkg::OFF_START && pwdata[adc_ctrl_pkg::START_NORMAL_BIT];
    assign hp_start_wr = wr_xfer && paddr == adc_ctrl_pkg::OFF_START && pwdata[adc_ctrl_pkg::START_PRIORITY_BIT];
    assign start_ok = start_wr && !busy_reg && !soft_rst && (!scan_reg || range_ok);
    assign refused_ev = start_wr && !busy_reg && scan_reg && !range_ok;
    assign end_conv = state_reg == adc_ctrl_pkg::ST_CONVERT && conv_valid;

    // Sequence end and interrupt boundary for the current normal conversion
    always_comb begin
        seq_last = 1'b0;
        norm_done_ev = 1'b0;
        if (end_conv && !hp_act_reg) begin
            if (scan_reg) begin
                norm_done_ev = ch_reg == LAST_CH;
                seq_last = norm_done_ev && !(repeat_reg && range_ok);
            end else if (repeat_reg) begin
                norm_done_ev = rep_cnt_reg == itm_reg;
            end else begin
                norm_done_ev = 1'b1;
                seq_last = 1'b1;
            end
        end
    end

    // Single repeat stops after the conversion in flight once repeat is cleared, scan repeat after the last channel
    assign norm_go_on = busy_reg && !seq_last && (scan_reg || repeat_reg || hp_act_reg);
    assign hp_done_ev = end_conv && hp_act_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
            busy_reg <= 1'b0;
            hp_pend_reg <= 1'b0;
            hp_act_reg <= 1'b0;
            ch_reg <= 4'h0;
            slot_reg <= 4'h0;
            rep_cnt_reg <= 3'h0;
            sh_cnt_reg <= 7'h0;
        end else if (soft_rst) begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
            busy_reg <= 1'b0;
            hp_pend_reg <= 1'b0;
            hp_act_reg <= 1'b0;
            rep_cnt_reg <= 3'h0;
            sh_cnt_reg <= 7'h0;
        end else begin
            if (hp_start_wr) begin
                hp_pend_reg <= 1'b1;
            end
            if (start_ok) begin
                busy_reg <= 1'b1;
                rep_cnt_reg <= 3'h0;
                ch_reg <= scan_reg ? scan_first : fix_ch_reg;
                slot_reg <= scan_reg ? scan_first : (repeat_reg ? 4'h0 : fix_ch_reg);
            end
            unique case (state_reg)
                adc_ctrl_pkg::ST_IDLE: begin
                    sh_cnt_reg <= 7'h0;
                    if (hp_pend_reg || hp_start_wr) begin
                        hp_pend_reg <= 1'b0;
                        hp_act_reg <= 1'b1;
                        state_reg <= adc_ctrl_pkg::ST_SAMPLE;
                    end else if (busy_reg || start_ok) begin
                        state_reg <= adc_ctrl_pkg::ST_SAMPLE;
                    end
                end
                adc_ctrl_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (sh_cnt_reg == sh_eff - 7'h1) begin
                            sh_cnt_reg <= 7'h0;
                            state_reg <= adc_ctrl_pkg::ST_CONVERT;
                        end else begin
                            sh_cnt_reg <= sh_cnt_reg + 7'h1;
                        end
                    end
                end
                adc_ctrl_pkg::ST_CONVERT: begin
                    if (end_conv) begin
                        hp_act_reg <= 1'b0;
                        if (!hp_act_reg) begin
                            if (scan_reg) begin
                                ch_reg <= (ch_reg == LAST_CH) ? scan_first : ch_reg + 4'h1;
                                slot_reg <= (ch_reg == LAST_CH) ? scan_first : ch_reg + 4'h1;
                            end else if (repeat_reg) begin
                                rep_cnt_reg <= norm_done_ev ? 3'h0 : rep_cnt_reg + 3'h1;
                                slot_reg <= norm_done_ev ? 4'h0 : {1'b0, rep_cnt_reg + 3'h1};
                            end
                            busy_reg <= norm_go_on;
                        end
                        if (hp_pend_reg) begin
                            hp_pend_reg <= 1'b0;
                            hp_act_reg <= 1'b1;
                            state_reg <= adc_ctrl_pkg::ST_SAMPLE;
                        end else if (hp_act_reg ? busy_reg : norm_go_on) begin
                            state_reg <= adc_ctrl_pkg::ST_SAMPLE;
                        end else begin
                            state_reg <= adc_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Priority requests convert their own channel into a separate slot
    assign analog_channel = hp_act_reg ? hp_ch_reg : ch_reg;
    assign sample_en = state_reg == adc_ctrl_pkg::ST_SAMPLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_req <= 1'b0;
        end else begin
            conv_req <= sample_en && tick && sh_cnt_reg == sh_eff - 7'h1 && !soft_rst;
        end
    end

    // ==========================================================
    // Result storage
    logic [DATA_WIDTH-1:0] rd_data;
    logic [3:0] rd_idx;

    assign rd_idx = (paddr == adc_ctrl_pkg::OFF_PRIORITY_RESULT) ? HP_SLOT :
        4'((paddr - adc_ctrl_pkg::OFF_RESULT_BASE) >> 2);

    result_store #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(adc_ctrl_pkg::NUM_CHANNELS + 1)
    ) u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(end_conv),
        .wr_idx(hp_act_reg ? HP_SLOT : slot_reg),
        .wr_data(conv_data),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // ==========================================================
    // Done flags, interrupts and DMA
    logic eocf_reg;
    logic hpeocf_reg;
    logic [adc_ctrl_pkg::IRQ_BITS-1:0] irq_stat_reg;
    logic [adc_ctrl_pkg::IRQ_BITS-1:0] irq_set;
    logic [adc_ctrl_pkg::IRQ_BITS-1:0] irq_clr;
    logic [adc_ctrl_pkg::DMA_DELAY-1:0] dma_pipe_reg;
    logic status_rd;

    assign status_rd = rd_xfer && paddr == adc_ctrl_pkg::OFF_STATUS;
    assign irq_set = {refused_ev, hp_done_ev, norm_done_ev};
    assign irq_clr = (wr_xfer && paddr == adc_ctrl_pkg::OFF_IRQ_CLEAR) ? pwdata[adc_ctrl_pkg::IRQ_BITS-1:0] : '0;

    // A new event in the read cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eocf_reg <= 1'b0;
            hpeocf_reg <= 1'b0;
        end else begin
            eocf_reg <= norm_done_ev || (eocf_reg && !status_rd);
            hpeocf_reg <= hp_done_ev || (hpeocf_reg && !status_rd);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_done_irq <= 1'b0;
            priority_done_irq <= 1'b0;
            dma_pipe_reg <= '0;
        end else begin
            normal_done_irq <= norm_done_ev;
            priority_done_irq <= hp_done_ev;
            // Interrupt pulse appears one clock after the event, request one more later
            dma_pipe_reg <= {dma_pipe_reg[adc_ctrl_pkg::DMA_DELAY-2:0],
                dma_en_reg && (norm_done_ev || hp_done_ev)};
        end
    end

    assign dma_req = dma_pipe_reg[adc_ctrl_pkg::DMA_DELAY-1];

    // ==========================================================
    // Read mux, latched in the first access cycle
    logic [31:0] prdata_reg;

    always_comb begin
        rd_mux = 32'h0;
        mapped = 1'b1;
        unique case (paddr)
            adc_ctrl_pkg::OFF_START: rd_mux[adc_ctrl_pkg::START_NORMAL_BIT] = busy_reg;
            adc_ctrl_pkg::OFF_POWER: rd_mux[0] = ref_en_reg;
            adc_ctrl_pkg::OFF_REPEAT: begin
                rd_mux[adc_ctrl_pkg::REPEAT_BIT] = repeat_reg;
                rd_mux[adc_ctrl_pkg::SCAN_BIT] = scan_reg;
                rd_mux[adc_ctrl_pkg::ITM_LSB +: 3] = itm_reg;
                rd_mux[adc_ctrl_pkg::FIX_CH_LSB +: 4] = fix_ch_reg;
                rd_mux[adc_ctrl_pkg::HP_CH_LSB +: 4] = hp_ch_reg;
            end
            adc_ctrl_pkg::OFF_SCAN: rd_mux[3:0] = scan_range_reg;
            adc_ctrl_pkg::OFF_STATUS: begin
                rd_mux[adc_ctrl_pkg::ST_EOCF_BIT] = eocf_reg;
                rd_mux[adc_ctrl_pkg::ST_HPEOCF_BIT] = hpeocf_reg;
                rd_mux[adc_ctrl_pkg::ST_BUSY_BIT] = busy_reg;
                rd_mux[adc_ctrl_pkg::ST_HP_PEND_BIT] = hp_pend_reg || hp_act_reg;
            end
            adc_ctrl_pkg::OFF_SOFT_RESET: rd_mux[0] = armed_reg;
            adc_ctrl_pkg::OFF_CLOCK: begin
                rd_mux[adc_ctrl_pkg::CLK_SEL_LSB +: 3] = clk_sel_reg;
                rd_mux[adc_ctrl_pkg::SH_LSB +: 7] = sh_reg;
            end
            adc_ctrl_pkg::OFF_DMA: rd_mux[0] = dma_en_reg;
            adc_ctrl_pkg::OFF_IRQ_STATUS: rd_mux[adc_ctrl_pkg::IRQ_BITS-1:0] = irq_stat_reg;
            adc_ctrl_pkg::OFF_IRQ_CLEAR: ;
            adc_ctrl_pkg::OFF_IRQ_ENABLE: rd_mux[adc_ctrl_pkg::IRQ_BITS-1:0] = irq_en_reg;
            adc_ctrl_pkg::OFF_PRIORITY_RESULT: rd_mux[DATA_WIDTH-1:0] = rd_data;
            default: begin
                if (paddr >= adc_ctrl_pkg::OFF_RESULT_BASE && paddr[1:0] == 2'h0
                    && rd_idx < HP_SLOT) begin
                    rd_mux[DATA_WIDTH-1:0] = rd_data;
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (access && !ack_reg && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    assign prdata = prdata_reg;

endmodule

// File: logic/result_store.sv
`timescale 1ns/1ps
module result_store #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);

    initial begin
        if (DEPTH > 16 || DEPTH < 1) begin
            $error("result_store depth must be 1 to 16");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en && int'(wr_idx) < DEPTH) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read keeps prdata glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else if (int'(rd_idx) < DEPTH) begin
            rd_data <= mem[rd_idx];
        end else begin
            rd_data <= '0;
        end
    end

endmodule

// File: tb/adc_ctrl_checker.sv
`timescale 1ns/1ps
module adc_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] analog_channel,
    input wire logic sample_en,
    input wire logic conv_req,
    input wire logic conv_valid,
    input wire logic normal_done_irq,
    input wire logic priority_done_irq,
    input wire logic dma_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [10:0] hold_cnt;

    // ==========================================================
    // Sample-hold length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 11'h000;
        end else if (sample_en) begin
            hold_cnt <= hold_cnt + 11'h001;
        end else begin
            hold_cnt <= 11'h000;
        end
    end

    apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready late");
    apb_err_a: assert property (pslverr |-> pready) else $error("lone pslverr");
    hold_len_a: assert property ($fell(sample_en) |-> hold_cnt >= 11'd10 && hold_cnt <= 11'd1120)
        else $error("hold length");
    conv_after_a: assert property (conv_req |-> !sample_en && ($past(sample_en) || $past(sample_en, 2)))
        else $error("early request");
    req_pulse_a: assert property (conv_req |=> !conv_req) else $error("long request");
    chan_hold_a: assert property (sample_en && $past(sample_en) |-> $stable(analog_channel))
        else $error("channel moved");
    done_cause_a: assert property (normal_done_irq || priority_done_irq |-> $past(conv_valid))
        else $error("stray done");
    done_pulse_a: assert property (normal_done_irq |=> !normal_done_irq) else $error("long done");
    dma_follow_a: assert property (dma_req |-> $past(normal_done_irq) || $past(priority_done_irq))
        else $error("stray dma");
endmodule
bind adc_ctrl adc_ctrl_checker i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .analog_channel,
    .sample_en, .conv_req, .conv_valid, .normal_done_irq, .priority_done_irq, .dma_req);

// File: tb/adc_result_mapping_and_stop_test.sv
`timescale 1ns/1ps
module adc_result_mapping_and_stop_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_valid = 1'b0, hold_off = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [11:0] conv_data = 12'h000, d;
    logic [3:0] analog_channel;
    logic pready, pslverr, sample_en, conv_req, reference_enable, normal_done_irq, priority_done_irq, dma_req, irq;
    int n_mismatch = 0, n_compared = 0, n_done = 0, cyc = 0, wait_cnt = 0;
    logic [3:0] hist_ch[$];
    logic [11:0] hist_d[$];

    always #25 pclk = ~pclk;

    adc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .analog_channel, .sample_en, .conv_req, .conv_valid, .conv_data, .reference_enable, .normal_done_irq,
        .priority_done_irq, .dma_req, .irq);

    // ==========================================================
    // Analog side, 1 to 4 clock answer
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        conv_valid <= 1'b0;
        if (normal_done_irq === 1'b1) begin
            n_done <= n_done + 1;
        end
        if (conv_req === 1'b1 && !hold_off) begin
            wait_cnt <= 1 + $urandom % 4;
        end else if (wait_cnt == 1) begin
            d = $urandom;
            conv_valid <= 1'b1;
            conv_data <= d;
            hist_ch.push_back(analog_channel);
            hist_d.push_back(d);
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
        if (cyc == 60000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ==========================================================
    // Helpers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge pclk);
        penable <= 1'b1;
        do @(negedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dw);
        apb(1'b1, a, dw);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdata & m);
    endtask

    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (n_done < n && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        chk("done wait", 32'h1, 32'(k < 4000));
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(negedge pclk);
        chk("irq line", 32'(e), 32'(irq));
    endtask

    function automatic int last_slot(int i, int n, int total);
        return i + ((total - 1 - i) / n) * n;
    endfunction

    task end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int n, k, nc;
        void'($urandom(72));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("hold reset", adc_ctrl_pkg::OFF_CLOCK, 32'hffff, 32'h0a00);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        wr(adc_ctrl_pkg::OFF_IRQ_ENABLE, 32'h7);
        wr(adc_ctrl_pkg::OFF_DMA, 32'h1);
        for (int ch = 0; ch < 12; ch++) begin
            n = n_done;
            wr(adc_ctrl_pkg::OFF_REPEAT, 32'(ch) << 8);
            wr(adc_ctrl_pkg::OFF_START, 32'h1);
            wait_done(n + 1);
            chk("fixed channel", 32'(ch), 32'(hist_ch[$]));
            rdchk("fixed result", adc_ctrl_pkg::OFF_RESULT_BASE + 8'(4 * ch), 32'hfff, 32'(hist_d[$]));
        end
        rdchk("done flag", adc_ctrl_pkg::OFF_STATUS, 32'h1, 32'h1);
        rdchk("done cleared", adc_ctrl_pkg::OFF_STATUS, 32'h1, 32'h0);
        for (int code = 0; code < 8; code++) begin
            hist_d.delete();
            n = n_done;
            // Random divider 1, 2 or 4 keeps the run short
            wr(adc_ctrl_pkg::OFF_CLOCK, 32'($urandom % 3) | 32'(10 + $urandom % 71) << 8);
            wr(adc_ctrl_pkg::OFF_REPEAT, 32'(code << 2 | 1) | 32'h500);
            wr(adc_ctrl_pkg::OFF_START, 32'h1);
            wait_done(n + 1);
            chk("repeat count", 32'(code + 1), 32'(hist_d.size()));
            wr(adc_ctrl_pkg::OFF_REPEAT, 32'h0);
            k = 0;
            do begin
                apb(1'b0, adc_ctrl_pkg::OFF_START, 32'h0);
                k++;
            end while (rdata[0] !== 1'b0 && k < 300);
            for (int i = 0; i <= code; i++) begin
                rdchk("repeat result", adc_ctrl_pkg::OFF_RESULT_BASE + 8'(4 * i), 32'hfff,
                    32'(hist_d[last_slot(i, code + 1, hist_d.size())]));
            end
        end
        wr(adc_ctrl_pkg::OFF_CLOCK, 32'h0a00);
        for (int t = 0; t < 5; t++) begin
            nc = (t == 0) ? 12 : (t == 1) ? 1 : 1 + $urandom % 12;
            hist_ch.delete();
            hist_d.delete();
            n = n_done;
            wr(adc_ctrl_pkg::OFF_SCAN, 32'(nc));
            wr(adc_ctrl_pkg::OFF_REPEAT, 32'h2);
            wr(adc_ctrl_pkg::OFF_START, 32'h1);
            wait_done(n + 1);
            chk("scan count", 32'(nc), 32'(hist_d.size()));
            for (int i = 0; i < nc; i++) begin
                chk("scan channel", 32'(12 - nc + i), 32'(hist_ch[i]));
                rdchk("scan result", adc_ctrl_pkg::OFF_RESULT_BASE + 8'(4 * (12 - nc + i)), 32'hfff,
                    32'(hist_d[i]));
            end
        end
        for (int v = 0; v < 14; v += 13) begin
            wr(adc_ctrl_pkg::OFF_IRQ_CLEAR, 32'h7);
            wr(adc_ctrl_pkg::OFF_SCAN, 32'(v));
            hist_d.delete();
            wr(adc_ctrl_pkg::OFF_START, 32'h1);
            rdchk("refused busy", adc_ctrl_pkg::OFF_START, 32'h1, 32'h0);
            rdchk("refused flag", adc_ctrl_pkg::OFF_IRQ_STATUS, 32'h4, 32'h4);
            chk("no conversion", 32'h0, 32'(hist_d.size()));
        end
        chk_irq(1'b1);
        wr(adc_ctrl_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk_irq(1'b0);
        wr(adc_ctrl_pkg::OFF_IRQ_ENABLE, 32'h7);
        chk_irq(1'b1);
        wr(adc_ctrl_pkg::OFF_IRQ_CLEAR, 32'h4);
        chk_irq(1'b0);
        // Analog side stays silent so the converter is caught busy
        hold_off <= 1'b1;
        wr(adc_ctrl_pkg::OFF_POWER, 32'h1);
        wr(adc_ctrl_pkg::OFF_REPEAT, 32'h300);
        wr(adc_ctrl_pkg::OFF_START, 32'h1);
        wr(adc_ctrl_pkg::OFF_SOFT_RESET, 32'h1);
        rdchk("lone fire", adc_ctrl_pkg::OFF_START, 32'h1, 32'h1);
        wr(adc_ctrl_pkg::OFF_CLOCK, 32'h0a02);
        wr(adc_ctrl_pkg::OFF_SOFT_RESET, 32'h2);
        wr(adc_ctrl_pkg::OFF_SOFT_RESET, 32'h1);
        rdchk("soft reset", adc_ctrl_pkg::OFF_START, 32'h1, 32'h0);
        chk("reference", 32'h1, 32'(reference_enable));
        end_sim();
    end
endmodule
